// *** include/sad_pkg.sv ***
// package: constants and carriers for the step attenuator control decoder
//
// Overview of operation
// R1: parallel lines weigh 0.5 dB doubling to 16
// R2: serial word bits one to six carry weights
// R3: address word low three bits, upper five low
// R4: normal mode limits changes to 400 kHz
// R5: bypass mode spaces changes by switching time
// R6: transitions never pass through lower attenuation
// R7: several set bits apply summed attenuation
// R8: interface select low parallel, high serial
// R9: sixteen bit frame, lsb first, word then address
// R10: latched frame applies only on address match
// R11: strobe low while shifting, then pulse high
package sad_pkg;

  localparam int unsigned CODE_W      = 6;
  localparam int unsigned FRAME_W     = 16;
  localparam int unsigned WORD_W      = 8;
  localparam int unsigned ATT_LSB     = 1;
  localparam int unsigned ADDR_LSB    = 8;
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned CNT_W       = 5;
  localparam int unsigned SYS_CLK_MHZ = 125;
  // longest switching time in ns; step spacing while bypassed
  localparam int unsigned SWITCH_NS   = 430;
  localparam int unsigned SWITCH_CYC  = (SWITCH_NS * SYS_CLK_MHZ) / 1000;
  // 400 kHz normal-mode rate, as a period in ns
  localparam int unsigned RATE_KHZ    = 400;
  localparam int unsigned RATE_NS     = 1000000 / RATE_KHZ;
  localparam int unsigned RATE_CYC    = (RATE_NS * SYS_CLK_MHZ) / 1000;
  localparam int unsigned GAP_W       = 12;
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h3f;
  localparam logic [CODE_W-1:0] CODE_REF = 6'h00;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [ADDR_W-1:0] addr;
    logic              pad_ok;
  } sad_frame_t;

endpackage

// *** rtl/sad_decode.sv ***
// control word decoder for a 6-bit digital step attenuator
`timescale 1ns/100ps
`default_nettype none
module sad_decode (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ser_clk_i,
  input  wire logic                      ser_data_i,
  input  wire logic                      latch_strobe_i,
  input  wire logic                      serial_sel_i,
  input  wire logic                      bypass_mode_i,
  input  wire logic [sad_pkg::CODE_W-1:0] par_code_i,
  input  wire logic [sad_pkg::ADDR_W-1:0] addr_strap_i,
  output logic      [sad_pkg::CODE_W-1:0] atten_code_o,
  output logic                           busy_o
);

  ////////////////////////////////////////////////////////////////////
  // link domain: shift register on the serial clock
  typedef struct packed {
    logic [sad_pkg::FRAME_W-1:0] shift;
  } sad_link_st_t;
  sad_link_st_t lk_q;
  sad_link_st_t lk_d;

  // lsb first: new bits enter at the top and move down [R9]
  always_comb begin
    lk_d       = lk_q;
    lk_d.shift = {ser_data_i, lk_q.shift[sad_pkg::FRAME_W-1:1]};
  end

  // link clock only runs during frames; no reset needed for data
  always_ff @(posedge ser_clk_i) begin
    lk_q <= lk_d;
  end

  ////////////////////////////////////////////////////////////////////
  // crossings: strobe, select, pins and straps as levels
  logic                          le_s;
  logic                          sel_s;
  logic                          byp_s;
  logic [sad_pkg::CODE_W-1:0]    par_s;
  logic [sad_pkg::ADDR_W-1:0]    strap_s;
  logic [sad_pkg::FRAME_W-1:0]   frame_s;

  sad_sync #(.W(3)) u_ctl_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({latch_strobe_i, serial_sel_i, bypass_mode_i}),
    .sync_o    ({le_s, sel_s, byp_s})
  );

  sad_sync #(.W(sad_pkg::CODE_W + sad_pkg::ADDR_W)) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({par_code_i, addr_strap_i}),
    .sync_o    ({par_s, strap_s})
  );

  // frame is stable while the strobe is high, since shifting is done [R11]
  sad_sync #(.W(sad_pkg::FRAME_W)) u_frame_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (lk_q.shift),
    .sync_o    (frame_s)
  );

  ////////////////////////////////////////////////////////////////////
  // system domain
  typedef enum logic [1:0] {ST_IDLE, ST_RAISE, ST_SETTLE} sad_ph_t;

  typedef struct packed {
    sad_ph_t                      ph;
    logic                         le_d1;
    logic [sad_pkg::CODE_W-1:0]   out;
    logic [sad_pkg::CODE_W-1:0]   target;
    logic [sad_pkg::CODE_W-1:0]   pend;
    logic                         pend_v;
    logic [sad_pkg::GAP_W-1:0]    gap;
    logic                         busy;
  } sad_st_t;
  sad_st_t st_q;
  sad_st_t st_d;

  sad_pkg::sad_frame_t fr;
  logic                latch_fall;
  logic [sad_pkg::GAP_W-1:0] gap_len;

  always_comb begin
    // attenuation bits sit one above the pad bit [R2] [R3]
    fr.code   = frame_s[sad_pkg::ATT_LSB +: sad_pkg::CODE_W];
    fr.addr   = frame_s[sad_pkg::ADDR_LSB +: sad_pkg::ADDR_W];
    // address word pads must be low, else the frame is not ours [R3]
    fr.pad_ok = frame_s[sad_pkg::FRAME_W-1:sad_pkg::ADDR_LSB+sad_pkg::ADDR_W]
                == '0;
    latch_fall = st_q.le_d1 & ~le_s;
    // normal mode holds the 400 kHz rate; bypass the switching time
    gap_len = byp_s ? sad_pkg::GAP_W'(sad_pkg::SWITCH_CYC)
                    : sad_pkg::GAP_W'(sad_pkg::RATE_CYC); // [R4] [R5]
  end

  always_comb begin
    st_d       = st_q;
    st_d.le_d1 = le_s;
    st_d.busy  = (st_q.ph != ST_IDLE) | st_q.pend_v;
    if (st_q.gap != '0) begin
      st_d.gap = st_q.gap - 1'b1;
    end
    // new request: serial applies only on address match [R8] [R10]
    if (sel_s) begin
      if (latch_fall && fr.addr == strap_s && fr.pad_ok) begin
        st_d.pend   = fr.code;
        st_d.pend_v = 1'b1;
      end
    end else if (le_s || latch_fall) begin
      // direct while strobe high, latched on its fall [R1] [R7]
      st_d.pend   = par_s;
      st_d.pend_v = (par_s != st_q.target) | st_q.pend_v;
    end
    case (st_q.ph)
      ST_IDLE: begin
        if (st_q.pend_v && st_q.gap == '0) begin
          st_d.target = st_q.pend;
          st_d.pend_v = st_d.pend_v & (st_d.pend != st_q.pend);
          // first add every new bit, never dropping one [R6]
          st_d.out    = st_q.out | st_q.pend;
          st_d.ph     = ST_RAISE;
          st_d.gap    = gap_len;
        end
      end
      ST_RAISE: begin
        st_d.ph = ST_SETTLE;
      end
      ST_SETTLE: begin
        // then clear the bits no longer wanted [R6]
        st_d.out = st_q.target;
        st_d.ph  = ST_IDLE;
      end
      default: begin
        st_d.ph = ST_IDLE;
      end
    endcase
  end

  // reset behaves as power-up with strobe low: maximum attenuation
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q        <= '0;
      st_q.ph     <= ST_IDLE;
      st_q.out    <= sad_pkg::CODE_MAX;
      st_q.target <= sad_pkg::CODE_MAX;
      st_q.pend   <= sad_pkg::CODE_MAX;
    end else begin
      st_q <= st_d;
    end
  end

  assign atten_code_o = st_q.out;
  assign busy_o       = st_q.busy;

  ////////////////////////////////////////////////////////////////////
  // checks
  a_raise_no_drop: assert property ( // [R6]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.ph == ST_RAISE |-> (st_q.out & $past(st_q.out)) == $past(st_q.out))
    else $error("bits dropped during raise");

  a_settle_to_target: assert property ( // [R7]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.ph == ST_SETTLE |=> st_q.out == $past(st_q.target))
    else $error("settle did not reach target");

  a_raise_superset: assert property ( // [R6]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.ph == ST_RAISE |-> (st_q.out & st_q.target) == st_q.target)
    else $error("raise lacks target bits");

  // output may only move on entering raise or leaving settle
  a_out_only_seq: assert property ( // [R6]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.ph == ST_IDLE ##1 st_q.ph == ST_IDLE |-> $stable(st_q.out))
    else $error("output moved outside a sequence");

  a_serial_mismatch: assert property ( // [R10]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    sel_s && latch_fall && fr.addr != strap_s && !st_q.pend_v
    && st_q.ph == ST_IDLE |=> !st_q.pend_v)
    else $error("mismatched address accepted");

  a_serial_pads: assert property ( // [R3]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    sel_s && latch_fall && !fr.pad_ok && !st_q.pend_v
    && st_q.ph == ST_IDLE |=> !st_q.pend_v)
    else $error("frame with raised pad bits accepted");

  a_serial_match: assert property ( // [R10]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    sel_s && latch_fall && fr.addr == strap_s && fr.pad_ok
    |=> st_q.pend_v || st_q.ph == ST_RAISE)
    else $error("matching frame not taken");

  a_gap_loaded: assert property ( // [R4]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.ph == ST_IDLE ##1 st_q.ph == ST_RAISE |->
    st_q.gap == $past(gap_len))
    else $error("spacing counter not loaded");

  a_spacing_held: assert property ( // [R5]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.ph == ST_IDLE && st_q.gap != '0 |=> st_q.ph == ST_IDLE)
    else $error("changes too close together");

  // with the load check this pins the full spacing window
  a_gap_countdown: assert property ( // [R5]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.gap != '0 |=> st_q.gap == $past(st_q.gap) - 1'b1)
    else $error("spacing counter skipped a step");

  a_parallel_code: assert property ( // [R1] [R8]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !sel_s && le_s && st_q.ph == ST_IDLE && st_q.gap == '0
    && !st_q.pend_v && par_s != st_q.target |=> st_q.pend == $past(par_s))
    else $error("parallel code not taken");

endmodule
`default_nettype wire

// *** rtl/sad_sync.sv ***
// two flop synchroniser for a level
`timescale 1ns/100ps
`default_nettype none
module sad_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sad_sync_st_t;
  sad_sync_st_t st_q;
  sad_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;
endmodule
`default_nettype wire

// *** tb/sad_ctrl_model.sv ***
// controller model: serial frames and latch strobe
`timescale 1ns/100ps
`default_nettype none
module sad_ctrl_model (
  input  wire logic sys_clk_i,
  output logic      ser_clk_o,
  output logic      ser_data_o,
  output logic      latch_strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    latch_strobe_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // link clock runs only inside a frame, 32 ns period
  task automatic send(input logic [15:0] frame);
    #3;
    for (int i = 0; i < 16; i++) begin
      ser_data_o = frame[i];
      #16 ser_clk_o = 1'b1;
      #16 ser_clk_o = 1'b0;
    end
    // released line must not keep the stale bit
    ser_data_o = ~frame[15];
    @(negedge sys_clk_i) latch_strobe_o = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    latch_strobe_o = 1'b0;
  endtask
  task automatic strobe(input logic lvl);
    @(negedge sys_clk_i) latch_strobe_o = lvl;
  endtask
endmodule
`default_nettype wire

// *** tb/sad_decode_bench.sv ***
// bench for the attenuator control decoder
`timescale 1ns/100ps
`default_nettype none
module sad_decode_bench;
  logic                         sys_clk_i, rst_n_i, sck, sdat, stb;
  logic                         sel, byp, busy;
  logic [sad_pkg::CODE_W-1:0]   par, att;
  logic [sad_pkg::ADDR_W-1:0]   strap;
  int                           n_mismatch, checks_done, n;
  logic [5:0]                   codes [10] = '{6'h00, 6'h01, 6'h02, 6'h04,
    6'h08, 6'h10, 6'h20, 6'h3f, 6'h2a, 6'h15};

  sad_ctrl_model u_sad_ctrl_model (.sys_clk_i(sys_clk_i), .ser_clk_o(sck),
    .ser_data_o(sdat), .latch_strobe_o(stb));
  sad_decode u_sad_decode (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .ser_clk_i(sck), .ser_data_i(sdat), .latch_strobe_i(stb),
    .serial_sel_i(sel), .bypass_mode_i(byp), .par_code_i(par),
    .addr_strap_i(strap), .atten_code_o(att), .busy_o(busy));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // pads low: word bit 0 and 7, address bits 3 to 7
  function automatic logic [15:0] frm(input logic [5:0] c,
                                      input logic [2:0] a);
    return {5'h00, a, 1'b0, c, 1'b0};
  endfunction
  // n = cycles until applied; mid-sequence values must not dip below
  task automatic wait_code(input logic [5:0] exp);
    logic [5:0] old;
    old = att;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1 n++;
      if (att !== old && att < exp) check(att, exp);
    end while (att !== exp && n < 1000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_serial();
    u_sad_ctrl_model.send(frm(6'h25, 3'h5));
    wait_code(6'h25);
    check(att, 6'h25);
    u_sad_ctrl_model.send(frm(6'h0a, 3'h2));
    repeat (4) @(negedge sys_clk_i);
    u_sad_ctrl_model.send(frm(6'h0a, 3'h5) | 16'h8000);
    repeat (400) @(negedge sys_clk_i);
    check(att, 6'h25);
    check(6'(busy), 6'h00);
  endtask
  task automatic t_par_select();
    @(negedge sys_clk_i) sel = 1'b0;
    par = 6'h11;
    repeat (4) @(negedge sys_clk_i);
    u_sad_ctrl_model.send(frm(6'h03, 3'h5));
    wait_code(6'h11);
    check(att, 6'h11);
  endtask
  task automatic t_par_codes();
    u_sad_ctrl_model.strobe(1'b1);
    foreach (codes[i]) begin
      @(negedge sys_clk_i) par = codes[i];
      wait_code(codes[i]);
      check(att, codes[i]);
    end
  endtask
  // second change right after the first is held off by the spacing
  task automatic t_space(input logic mode, input int gap);
    @(negedge sys_clk_i) byp = mode;
    repeat (4) @(negedge sys_clk_i);
    par = 6'h01;
    wait_code(6'h01);
    @(negedge sys_clk_i) par = 6'h02;
    repeat (8) @(negedge sys_clk_i);
    check(6'(busy), 6'h01);
    wait_code(6'h02);
    check(6'(n + 8 >= gap - 2), 6'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rst_n_i = 1'b0;
    sel = 1'b1;
    byp = 1'b1;
    par = 6'h00;
    strap = 3'h5;
    repeat (10) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    check(att, sad_pkg::CODE_MAX);
    check(6'(busy), 6'h00);
    t_serial();
    t_par_select();
    t_par_codes();
    t_space(1'b1, sad_pkg::SWITCH_CYC);
    t_space(1'b0, sad_pkg::RATE_CYC);
    test_done();
  end
  // whole run is near 1700 cycles
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
